/* File: verilog/ipm_i2c_port.sv */
`timescale 1ns/100ps
`include "ipm_regs.svh"
module ipm_i2c_port (
   // clocks and reset
   input logic clk_i,
   input logic srst_i,
   input logic scl_lnk_clk_i,
   // bus pins, open drain
   input logic scl_i,
   output logic scl_o,
   output logic scl_oe_o,
   input logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   // configuration strap
   input logic mask_scheme_cfg_bit_i,
   // software registers
   input ipm_pkg::ipm_wr_t sw_wr_i,
   output ipm_pkg::ipm_regs_t regs_o,
   input logic irq_clr_i,
   output logic serial_irq_flag_o,
   // received byte stream
   output ipm_pkg::ipm_rx_t rx_o,
   input logic rx_ready_i
);
   import ipm_pkg::*;

   ipm_core_t core_reg;
   ipm_core_t core_next;
   logic [1:0] lk_sync_reg;
   logic lk_tog_reg;
   logic lk_bit_reg;
   logic sfall;
   logic sstart;
   logic sstop;
   logic bev;
   logic bv;
   logic mst;
   logic slv;
   logic ten;
   logic stt;
   logic tk;
   logic room;
   logic pop;
   logic push;
   logic iset;
   logic ok;
   logic bufw;
   logic [7:0] mk;

   // ------------------------------
   // helpers
   // ------------------------------
   function automatic logic [7:0] ipm_mask(input logic s7, input logic tb,
      input logic [7:0] c2, input logic [7:0] am);
      logic [7:0] m;
      if (s7) begin
         m = tb ? ~am : {~am[7:1], 1'h1};
      end else if (tb) begin
         m = {2'h0, c2[`IPM_C2_MSK_HI], c2[`IPM_C2_MSK1], c2[`IPM_C2_MSK1]}; // RULE16
      end else begin
         m = {2'h0, c2[`IPM_C2_MSK], 1'h1}; // RULE13 RULE14 RULE15
      end
      return m;
   endfunction

   function automatic logic ipm_hit(input logic [7:0] b, input logic [7:0] a,
      input logic [7:0] m);
      return &(~(b ^ a) | m); // RULE9
   endfunction

   function automatic logic [7:0] ipm_shl(input logic [7:0] v, input logic b);
      return {v[6:0], b};
   endfunction

   // ------------------------------
   // link domain: one toggle and one sample per SCL rise
   // ------------------------------
   // the link clock may stop, so it carries only a bit and a toggle;
   // framing is all done on clk_i
   always_ff @(posedge scl_lnk_clk_i) begin
      lk_sync_reg <= {lk_sync_reg[0], srst_i};
      if (lk_sync_reg[1]) begin
         lk_tog_reg <= 1'h0;
         lk_bit_reg <= 1'h0;
      end else begin
         lk_tog_reg <= ~lk_tog_reg;
         lk_bit_reg <= sda_i;
      end
   end

   // ------------------------------
   // core next state
   // ------------------------------
   always_comb begin
      core_next = core_reg;
      push = 1'h0;
      iset = 1'h0;
      ok = 1'h0;
      core_next.sc = {core_reg.sc[1:0], scl_i};
      core_next.sd = {core_reg.sd[1:0], sda_i};
      core_next.tg = {core_reg.tg[2:0], lk_tog_reg};
      core_next.tv = {core_reg.tv[0], lk_bit_reg};
      mst = core_reg.c1[`IPM_C1_EN] && core_reg.c1[`IPM_C1_MODE] == `IPM_MODE_MST;
      ten = core_reg.c1[`IPM_C1_MODE] == `IPM_MODE_SL10;
      slv = core_reg.c1[`IPM_C1_EN] && (ten || core_reg.c1[`IPM_C1_MODE] == `IPM_MODE_SL7);
      stt = core_reg.st == IPM_M_START;
      sfall = core_reg.sc[2] && !core_reg.sc[1];
      sstart = core_reg.sc[2] && core_reg.sc[1] && core_reg.sd[2] && !core_reg.sd[1];
      sstop = core_reg.sc[2] && core_reg.sc[1] && !core_reg.sd[2] && core_reg.sd[1];
      // value sync is one stage shorter than the toggle path so the bit has settled
      bev = core_reg.tg[3] ^ core_reg.tg[2];
      bv = core_reg.tv[1];
      tk = core_reg.brg == 7'h00;
      pop = rx_ready_i && core_reg.cnt != 2'h0;
      room = core_reg.cnt != `IPM_FIFO_DEPTH;
      bufw = sw_wr_i.en && sw_wr_i.sel == `IPM_SEL_BUF;
      mk = ipm_mask(core_reg.sch, ten && core_reg.tlo, core_reg.c2, core_reg.msk); // RULE11

      if (mst) begin
         core_next.brg = tk ? core_reg.addr[`IPM_BRG] : core_reg.brg - 7'h01; // RULE5
      end
      if (core_reg.c1[`IPM_C1_EN] && sstart) begin
         core_next.stat[`IPM_ST_S] = 1'h1; // RULE2
         core_next.stat[`IPM_ST_P] = 1'h0;
         iset = 1'h1;
      end else if (core_reg.c1[`IPM_C1_EN] && sstop) begin
         core_next.stat[`IPM_ST_P] = 1'h1; // RULE2
         core_next.stat[`IPM_ST_S] = 1'h0;
         iset = 1'h1;
      end

      unique case (core_reg.st)
         IPM_IDLE: begin
            if (mst && tk) begin // RULE1
               if (core_reg.c2[`IPM_C2_SEN] || core_reg.c2[`IPM_C2_PEN]) begin
                  core_next.st = core_reg.c2[`IPM_C2_SEN] ? IPM_M_START : IPM_M_STOP;
                  core_next.ph = 2'h0;
               end else if (core_reg.txp || (core_reg.c2[`IPM_C2_RCEN] && room)) begin
                  core_next.st = IPM_M_XFER;
                  core_next.mrx = !core_reg.txp;
                  core_next.txp = 1'h0;
                  core_next.ph = 2'h0;
                  core_next.bitc = 4'h0;
               end
            end
         end
         IPM_M_START, IPM_M_STOP: begin
            if (tk) begin
               core_next.ph = core_reg.ph + 2'h1;
               if (core_reg.ph == 2'h0) begin
                  core_next.sda_oe = !stt;
                  core_next.scl_oe = core_reg.scl_oe && !stt;
               end else if (core_reg.ph == 2'h1) begin
                  core_next.sda_oe = 1'h1;
                  core_next.scl_oe = 1'h0;
               end else begin
                  core_next.sda_oe = stt;
                  core_next.scl_oe = stt;
                  core_next.st = IPM_IDLE;
                  core_next.c2[stt ? `IPM_C2_SEN : `IPM_C2_PEN] = 1'h0;
               end
            end
         end
         IPM_M_XFER: begin
            if (tk) begin
               core_next.ph = core_reg.ph + 2'h1;
               if (core_reg.ph == 2'h0) begin
                  if (core_reg.bitc == `IPM_LAST_BIT) begin
                     core_next.sda_oe = core_reg.mrx && !core_reg.c2[`IPM_C2_ACKDT]; // RULE18
                  end else begin
                     core_next.sda_oe = !core_reg.mrx && !core_reg.tsh[`IPM_MSB];
                  end
               end else if (core_reg.ph == 2'h1) begin
                  core_next.scl_oe = 1'h0;
               end else begin
                  core_next.ph = 2'h0;
                  core_next.scl_oe = 1'h1;
                  core_next.bitc = core_reg.bitc + 4'h1;
                  if (core_reg.bitc == `IPM_LAST_BIT) begin
                     core_next.st = IPM_IDLE;
                     core_next.sda_oe = 1'h0;
                     core_next.c2[`IPM_C2_RCEN] = 1'h0;
                     if (core_reg.mrx) begin
                        push = 1'h1;
                     end else begin
                        core_next.c2[`IPM_C2_ACKST] = core_reg.sd[1];
                        iset = 1'h1;
                     end
                  end else begin
                     core_next.sh = ipm_shl(core_reg.sh, core_reg.sd[1]);
                     core_next.tsh = ipm_shl(core_reg.tsh, 1'h0);
                  end
               end
            end
         end
         IPM_S_ADDR, IPM_S_RX: begin
            if (bev && core_reg.bitc != `IPM_LAST_BIT) begin
               core_next.sh = ipm_shl(core_reg.sh, bv);
               core_next.bitc = core_reg.bitc + 4'h1;
            end
            if (sfall && core_reg.bitc == `IPM_LAST_BIT) begin
               if (core_reg.st == IPM_S_RX) begin
                  core_next.st = IPM_S_ACK;
                  core_next.stat[`IPM_ST_DA] = 1'h1;
                  // full buffer answers with a not-acknowledge, nothing is lost
                  push = room; // RULE7
                  core_next.sda_oe = room; // RULE18
               end else begin
                  if (ten && !core_reg.tlo) begin
                     ok = core_reg.sh[`IPM_TENB_TAG] == `IPM_TENB_HDR &&
                        core_reg.sh[`IPM_TENB_HI] == core_reg.addr[`IPM_TENB_HI] &&
                        (!core_reg.sh[0] || core_reg.hiok); // RULE3 RULE17
                  end else begin
                     ok = ipm_hit(core_reg.sh, core_reg.addr, mk); // RULE3 RULE9
                  end
                  ok = (ok || (core_reg.c2[`IPM_C2_GCEN] && core_reg.sh == `IPM_GCALL)) &&
                     room; // RULE1
                  if (ok) begin
                     push = 1'h1; // RULE10
                     core_next.sda_oe = 1'h1; // RULE18
                     core_next.st = IPM_S_ACK;
                     core_next.stat[`IPM_ST_DA] = 1'h0;
                     core_next.tlo = ten && !core_reg.tlo && !core_reg.sh[0];
                     core_next.stat[`IPM_ST_UA] = ten && !core_reg.tlo && !core_reg.sh[0];
                     core_next.hiok = core_reg.hiok || core_reg.tlo;
                     if (!core_reg.tlo) begin
                        core_next.stat[`IPM_ST_RW] = core_reg.sh[0];
                     end
                  end else begin
                     core_next.st = IPM_IDLE;
                  end
               end
            end
         end
         IPM_S_ACK: begin
            if (sfall) begin
               core_next.sda_oe = 1'h0;
               core_next.bitc = 4'h0;
               if (core_reg.tlo) begin
                  core_next.st = IPM_S_ADDR;
               end else if (core_reg.stat[`IPM_ST_RW]) begin
                  core_next.st = IPM_S_HOLD;
                  core_next.scl_oe = 1'h1;
               end else begin
                  core_next.st = IPM_S_RX;
               end
            end
         end
         IPM_S_HOLD: begin
            // clock is stretched until software supplies the next byte
            if (bufw) begin
               core_next.st = IPM_S_TX;
               core_next.sda_oe = !sw_wr_i.data[`IPM_MSB];
               core_next.bitc = 4'h0;
            end
         end
         IPM_S_TX: begin
            // release one cycle after the first bit so data leads the clock
            core_next.scl_oe = 1'h0;
            if (bev) begin
               core_next.bitc = core_reg.bitc + 4'h1;
               core_next.tsh = ipm_shl(core_reg.tsh, 1'h0);
            end
            if (sfall) begin
               if (core_reg.bitc == `IPM_LAST_BIT) begin
                  core_next.sda_oe = 1'h0;
                  core_next.st = IPM_S_TACK;
               end else begin
                  core_next.sda_oe = !core_reg.tsh[`IPM_MSB];
               end
            end
         end
         IPM_S_TACK: begin
            if (bev) begin
               core_next.ack = !bv;
            end
            if (sfall) begin
               if (core_reg.ack) begin
                  core_next.st = IPM_S_HOLD;
                  core_next.scl_oe = 1'h1;
                  iset = 1'h1;
               end else begin
                  core_next.st = IPM_IDLE;
               end
            end
         end
         default: begin
            core_next.st = IPM_IDLE;
         end
      endcase

      if (slv && sstart) begin
         core_next.st = IPM_S_ADDR;
         core_next.bitc = 4'h0;
         core_next.sda_oe = 1'h0;
         core_next.scl_oe = 1'h0;
      end else if (slv && sstop) begin
         core_next.st = IPM_IDLE;
         core_next.sda_oe = 1'h0;
         core_next.scl_oe = 1'h0;
         core_next.hiok = 1'h0;
         core_next.tlo = 1'h0;
      end
      if (!core_reg.c1[`IPM_C1_EN]) begin
         core_next.st = IPM_IDLE;
         core_next.sda_oe = 1'h0;
         core_next.scl_oe = 1'h0;
      end

      // software writes come last and override hardware updates; only a UA set in the same cycle survives
      if (sw_wr_i.en) begin // RULE4
         case (sw_wr_i.sel)
            `IPM_SEL_CON1: core_next.c1 = sw_wr_i.data;
            `IPM_SEL_CON2: core_next.c2 = sw_wr_i.data;
            `IPM_SEL_STAT: core_next.stat[`IPM_ST_SW] = sw_wr_i.data[`IPM_ST_SW];
            `IPM_SEL_BUF: begin
               core_next.tsh = sw_wr_i.data; // RULE8
               core_next.txp = core_next.txp || mst;
            end
            `IPM_SEL_ADDR: begin
               if (core_reg.c1[`IPM_C1_MODE] == `IPM_MODE_MSKACC) begin
                  core_next.msk = sw_wr_i.data; // RULE6
               end else begin
                  core_next.addr = sw_wr_i.data;
                  core_next.stat[`IPM_ST_UA] =
                     core_next.stat[`IPM_ST_UA] && !core_reg.stat[`IPM_ST_UA];
               end
            end
            default: begin
            end
         endcase
      end

      // two-entry receive buffer
      if (push) begin
         core_next.mem[core_reg.wp] = core_reg.sh; // RULE7
         core_next.wp = !core_reg.wp;
         iset = 1'h1;
      end
      if (pop) begin
         core_next.rp = !core_reg.rp;
      end
      core_next.cnt = core_reg.cnt + {1'h0, push} - {1'h0, pop};
      core_next.stat[`IPM_ST_BF] = core_next.cnt != 2'h0;
      core_next.irq = (core_reg.irq && !irq_clr_i) || iset;

      if (srst_i) begin
         core_next = '0;
         core_next.msk = `IPM_MSK_RST;
         core_next.sch = mask_scheme_cfg_bit_i; // RULE11 RULE12
      end
   end

   always_ff @(posedge clk_i) begin
      core_reg <= core_next;
   end

   // ------------------------------
   // outputs
   // ------------------------------
   assign scl_o = 1'h0;
   assign sda_o = 1'h0;
   assign scl_oe_o = core_reg.scl_oe;
   assign sda_oe_o = core_reg.sda_oe;
   assign serial_irq_flag_o = core_reg.irq;
   assign rx_o.valid = core_reg.cnt != 2'h0;
   assign rx_o.data = core_reg.mem[core_reg.rp];
   assign regs_o.con1 = core_reg.c1;
   assign regs_o.con2 = core_reg.c2;
   assign regs_o.stat = core_reg.stat;
   assign regs_o.addr = (core_reg.c1[`IPM_C1_MODE] == `IPM_MODE_MSKACC) ?
      core_reg.msk : core_reg.addr; // RULE6

endmodule

/* File: verilog/ipm_regs.svh */
// Overview of operation
// [RULE1] master and slave roles, general call recognised
// [RULE2] start and stop detected, flagged, raise interrupt
// [RULE3] slave addresses in 7-bit or 10-bit form
// [RULE4] status low six read-only, controls fully writable
// [RULE5] master mode: address low seven bits reload clock
// [RULE6] mask shares address slot, mask-access mode only
// [RULE7] full received byte moves to buffer, sets flag
// [RULE8] buffer write loads buffer and shifter together; here a buffer write loads only the shifter tsh
// [RULE9] masked address bits are ignored in compare
// [RULE10] address byte kept in buffer for software
// [RULE11] masking scheme picked by configuration strap, 7-bit default
// [RULE12] strap low selects the 5-bit scheme
// [RULE13] 5-bit scheme masks incoming address bits 5:1
// [RULE14] 5-bit mask lives in control two bits 5:1
// [RULE15] 7-bit addresses: set bit excludes that bit
// [RULE16] 10-bit: bits 5:2 direct, bit 1 masks 1:0
// [RULE17] 10-bit upper two address bits never masked
// [RULE18] acknowledge pulls data low in ninth clock
`ifndef IPM_REGS_SVH
`define IPM_REGS_SVH

// ------------------------------
// register selects
// ------------------------------
`define IPM_SEL_CON1 3'h0
`define IPM_SEL_CON2 3'h1
`define IPM_SEL_STAT 3'h2
`define IPM_SEL_BUF 3'h3
`define IPM_SEL_ADDR 3'h4

// ------------------------------
// port modes
// ------------------------------
`define IPM_MODE_SL7 4'h6
`define IPM_MODE_SL10 4'h7
`define IPM_MODE_MST 4'h8
`define IPM_MODE_MSKACC 4'h9

// ------------------------------
// field positions
// ------------------------------
`define IPM_C1_EN 5
`define IPM_C1_MODE 3:0
`define IPM_C2_SEN 0
`define IPM_C2_MSK1 1
`define IPM_C2_PEN 2
`define IPM_C2_RCEN 3
`define IPM_C2_ACKDT 5
`define IPM_C2_ACKST 6
`define IPM_C2_GCEN 7
`define IPM_C2_MSK 5:1
`define IPM_C2_MSK_HI 5:2
`define IPM_ST_BF 0
`define IPM_ST_UA 1
`define IPM_ST_RW 2
`define IPM_ST_S 3
`define IPM_ST_P 4
`define IPM_ST_DA 5
`define IPM_ST_SW 7:6
`define IPM_MSB 7
`define IPM_TENB_TAG 7:3
`define IPM_TENB_HI 2:1
`define IPM_BRG 6:0

// ------------------------------
// values
// ------------------------------
`define IPM_TENB_HDR 5'h1E
`define IPM_GCALL 8'h00
`define IPM_MSK_RST 8'hFF
`define IPM_LAST_BIT 4'h8
`define IPM_FIFO_DEPTH 2'h2

`endif

/* File: verilog/ipm_pkg.sv */
package ipm_pkg;

   // ------------------------------
   // engine states
   // ------------------------------
   typedef enum logic [3:0] {
      IPM_IDLE = 4'h0,
      IPM_S_ADDR = 4'h1,
      IPM_S_ACK = 4'h2,
      IPM_S_RX = 4'h3,
      IPM_S_TX = 4'h4,
      IPM_S_TACK = 4'h5,
      IPM_S_HOLD = 4'h6,
      IPM_M_START = 4'h7,
      IPM_M_STOP = 4'h8,
      IPM_M_XFER = 4'h9
   } ipm_state_t;

   // ------------------------------
   // software side carriers
   // ------------------------------
   typedef struct packed {
      logic en;
      logic [2:0] sel;
      logic [7:0] data;
   } ipm_wr_t;

   typedef struct packed {
      logic [7:0] con1;
      logic [7:0] con2;
      logic [7:0] stat;
      logic [7:0] addr;
   } ipm_regs_t;

   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } ipm_rx_t;

   // ------------------------------
   // whole core state
   // ------------------------------
   typedef struct packed {
      ipm_state_t st;
      logic [7:0] c1;
      logic [7:0] c2;
      logic [7:0] stat;
      logic [7:0] addr;
      logic [7:0] msk;
      logic [7:0] sh;
      logic [7:0] tsh;
      logic [3:0] bitc;
      logic [1:0] ph;
      logic [6:0] brg;
      logic [1:0][7:0] mem;
      logic wp;
      logic rp;
      logic [1:0] cnt;
      logic irq;
      logic sch;
      logic tlo;
      logic hiok;
      logic ack;
      logic mrx;
      logic txp;
      logic sda_oe;
      logic scl_oe;
      logic [2:0] sc;
      logic [2:0] sd;
      logic [3:0] tg;
      logic [1:0] tv;
   } ipm_core_t;

endpackage

/* File: dv/ipm_i2c_port_sva.sv */
`timescale 1ns/100ps
module ipm_i2c_port_sva (
   // clocks and reset
   input logic clk_i,
   input logic srst_i,
   input logic scl_lnk_clk_i,
   // bus pins
   input logic scl_i,
   input logic scl_o,
   input logic scl_oe_o,
   input logic sda_i,
   input logic sda_o,
   input logic sda_oe_o,
   // software side
   input ipm_pkg::ipm_wr_t sw_wr_i,
   input ipm_pkg::ipm_regs_t regs_o,
   input logic serial_irq_flag_o,
   input ipm_pkg::ipm_rx_t rx_o,
   input logic rx_ready_i
);
   import ipm_pkg::*;
   // ----------------------------
   // core clock checks
   // ----------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (srst_i);
   logic slave;
   assign slave = regs_o.con1[3:1] == 3'h3;
   sequence reg_take(logic [2:0] s);
      sw_wr_i.en && sw_wr_i.sel == s;
   endsequence
   // raw pins: the core adds its own synchroniser delay, hence the window
   sequence start_cond;
      $fell(sda_i) && scl_i && regs_o.con1[5];
   endsequence
   sequence stop_cond;
      $rose(sda_i) && scl_i && regs_o.con1[5];
   endsequence
   pins_low_a: assert property (!scl_o && !sda_o)
      else $error("open drain pin driven high");
   con1_write_a: assert property (reg_take(3'h0) |=> regs_o.con1 == $past(sw_wr_i.data))
      else $error("control one readback wrong");
   stat_write_a: assert property (reg_take(3'h2) |=> regs_o.stat[7:6] == $past(sw_wr_i.data[7:6]))
      else $error("status upper bits not written");
   stat_hold_a: assert property (!(sw_wr_i.en && sw_wr_i.sel == 3'h2) |=> $stable(regs_o.stat[7:6]))
      else $error("status upper bits changed by hardware");
   addr_write_a: assert property (reg_take(3'h4) |=> regs_o.addr == $past(sw_wr_i.data))
      else $error("address slot readback wrong");
   rx_hold_a: assert property (rx_o.valid && !rx_ready_i |=> rx_o.valid && $stable(rx_o.data))
      else $error("receive head lost while stalled");
   rx_irq_a: assert property ($rose(rx_o.valid) |-> ##[0:2] serial_irq_flag_o)
      else $error("byte stored without flag");
   ack_hold_a: assert property ($rose(sda_oe_o) && slave |-> sda_oe_o [*8])
      else $error("acknowledge pulse too short");
   ack_edge_a: assert property ($changed(sda_oe_o) && slave |-> !scl_i)
      else $error("data line moved while clock high");
   start_seen_a: assert property (start_cond |-> ##[1:10] (regs_o.stat[3] && serial_irq_flag_o))
      else $error("start not recorded");
   stop_seen_a: assert property (stop_cond |-> ##[1:10] regs_o.stat[4])
      else $error("stop not recorded");
endmodule

bind ipm_i2c_port ipm_i2c_port_sva u_sva (.clk_i(clk_i), .srst_i(srst_i),
   .scl_lnk_clk_i(scl_lnk_clk_i), .scl_i(scl_i), .scl_o(scl_o), .scl_oe_o(scl_oe_o),
   .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .sw_wr_i(sw_wr_i), .regs_o(regs_o),
   .serial_irq_flag_o(serial_irq_flag_o), .rx_o(rx_o), .rx_ready_i(rx_ready_i));

/* File: dv/ipm_i2c_master_model.sv */
`timescale 1ns/100ps
module ipm_i2c_master_model (
   // resolved bus wires
   input logic scl_w_i,
   input logic sda_w_i,
   // open drain pulls, high pulls the wire low
   output logic scl_low_o,
   output logic sda_low_o
);
   // ----------------------------
   // remote master, clock runs inside frames and in pulse_scl
   // ----------------------------
   localparam realtime HALF = 32.0;
   localparam realtime QTR = 16.0;
   initial begin
      scl_low_o = 1'b0;
      sda_low_o = 1'b0;
   end
   task automatic pulse_scl();
      #(HALF) scl_low_o = 1'b1;
      #(HALF) scl_low_o = 1'b0;
   endtask
   task automatic start();
      #(QTR) sda_low_o = 1'b0;
      #(QTR) scl_low_o = 1'b0;
      wait (scl_w_i);
      #(HALF) sda_low_o = 1'b1;
      #(HALF) scl_low_o = 1'b1;
   endtask
   // data moves only while the clock is low; a slave may stretch that phase
   task automatic clock_bit(input logic v, output logic seen);
      #(QTR) sda_low_o = !v;
      #(QTR) scl_low_o = 1'b0;
      wait (scl_w_i);
      #(HALF) seen = sda_w_i;
      scl_low_o = 1'b1;
   endtask
   task automatic send_byte(input logic [7:0] b, output logic ack);
      logic seen;
      for (int i = 7; i >= 0; i--) begin
         clock_bit(b[i], seen);
      end
      clock_bit(1'b1, seen);
      ack = !seen;
   endtask
   task automatic stop();
      #(QTR) sda_low_o = 1'b1;
      #(QTR) scl_low_o = 1'b0;
      wait (scl_w_i);
      #(HALF) sda_low_o = 1'b0;
      #(HALF);
   endtask
endmodule

/* File: dv/ipm_i2c_port_bench.sv */
`timescale 1ns/100ps
module ipm_i2c_port_bench;
   import ipm_pkg::*;
   // ----------------------------
   // bench signals
   // ----------------------------
   logic clk_i, srst_i, strap, irq_clr, irq, rx_ready;
   logic scl_o_s, scl_oe, sda_o_s, sda_oe, m_scl_low, m_sda_low, scl_w, sda_w;
   ipm_wr_t sw_wr;
   ipm_regs_t regs;
   ipm_rx_t rx;
   int miscompares, check_count;
   logic [7:0] q[$];
   logic [7:0] adr, msk, c2;
   // pull-ups on both wires: a released line reads high
   assign scl_w = (scl_oe ? scl_o_s : 1'b1) && !m_scl_low;
   assign sda_w = (sda_oe ? sda_o_s : 1'b1) && !m_sda_low;
   ipm_i2c_port dut (.clk_i(clk_i), .srst_i(srst_i), .scl_lnk_clk_i(scl_w), .scl_i(scl_w),
      .scl_o(scl_o_s), .scl_oe_o(scl_oe), .sda_i(sda_w), .sda_o(sda_o_s), .sda_oe_o(sda_oe),
      .mask_scheme_cfg_bit_i(strap), .sw_wr_i(sw_wr), .regs_o(regs), .irq_clr_i(irq_clr),
      .serial_irq_flag_o(irq), .rx_o(rx), .rx_ready_i(rx_ready));
   ipm_i2c_master_model bfm (.scl_w_i(scl_w), .sda_w_i(sda_w), .scl_low_o(m_scl_low),
      .sda_low_o(m_sda_low));
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = !clk_i;
   end
   // ----------------------------
   // helpers
   // ----------------------------
   task automatic check(input logic ok, input string what);
      check_count++;
      if (ok !== 1'b1) begin
         miscompares++;
         $display("unexpected at %0t: %s", $time, what);
      end
   endtask
   function automatic logic hit(input logic [7:0] a, ad, mk, cc, input logic sch, ten);
      logic [7:0] care;
      care = sch ? mk : ~{2'b00, cc[5:2], cc[1], cc[1] & ten};
      return ((a ^ ad) & care & {7'h7F, ten}) == 8'h00;
   endfunction
   task automatic wr(input logic [2:0] sel, input logic [7:0] d);
      @(negedge clk_i);
      sw_wr = '{en: 1'b1, sel: sel, data: d};
      @(negedge clk_i);
      sw_wr.en = 1'b0;
      @(negedge clk_i);
   endtask
   task automatic do_reset(input logic sch);
      @(negedge clk_i);
      srst_i = 1'b1;
      strap = sch;
      fork
         repeat (20) @(negedge clk_i);
         repeat (3) bfm.pulse_scl();
      join
      @(negedge clk_i);
      srst_i = 1'b0;
      repeat (2) bfm.pulse_scl();
      @(negedge clk_i);
   endtask
   task automatic begin_frame();
      @(negedge clk_i);
      irq_clr = 1'b1;
      @(negedge clk_i);
      irq_clr = 1'b0;
      @(negedge clk_i);
      check(irq === 1'b0, "flag not cleared");
      bfm.start();
      @(negedge clk_i);
      check(regs.stat[3] === 1'b1 && irq === 1'b1, "start not flagged");
   endtask
   task automatic byte_out(input logic [7:0] b, input logic exp);
      logic ack;
      bfm.send_byte(b, ack);
      if (ack === 1'b1) q.push_back(b);
      check(ack === exp, "acknowledge differs");
   endtask
   task automatic end_frame();
      bfm.stop();
      @(negedge clk_i);
      check(regs.stat[4] === 1'b1 && irq === 1'b1, "stop not flagged");
      while (q.size() > 0) begin
         check(rx.valid === 1'b1 && rx.data === q.pop_front(), "received byte");
         rx_ready = 1'b1;
         @(negedge clk_i);
         rx_ready = 1'b0;
         @(negedge clk_i);
      end
      check(rx.valid === 1'b0, "buffer not empty");
   endtask
   task automatic trial(input logic sch, input logic [7:0] a, input int nd);
      logic e;
      e = hit(a, adr, msk, c2, sch, 1'b0) || (a === 8'h00 && c2[7]);
      begin_frame();
      byte_out(a, e);
      repeat (nd) byte_out(8'($urandom), e && q.size() < 2);
      end_frame();
   endtask
   task automatic summarize();
      if (miscompares == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // ----------------------------
   // main sequence
   // ----------------------------
   initial begin
      logic [7:0] d, lo, b;
      logic [1:0] hi, hh;
      srst_i = 1'b1;
      strap = 1'b1;
      sw_wr = '0;
      irq_clr = 1'b0;
      rx_ready = 1'b0;
      miscompares = 0;
      check_count = 0;
      void'($urandom(32'h0480));
      for (int s = 1; s >= 0; s--) begin
         do_reset(s[0]);
         check(regs === 32'h0 && irq === 1'b0 && rx.valid === 1'b0 && sda_oe === 1'b0
            && scl_oe === 1'b0, "reset state");
         d = 8'($urandom);
         wr(3'h0, d & 8'hDF);
         wr(3'h1, d);
         wr(3'h2, d);
         check(regs.con1 === (d & 8'hDF) && regs.con2 === d, "control readback");
         check(regs.stat === {d[7:6], 6'h00}, "status read-only bits");
         adr = 8'($urandom) | 8'h80;
         msk = 8'hFF ^ (8'($urandom) & 8'h3E);
         wr(3'h0, 8'h29);
         wr(3'h4, msk);
         wr(3'h0, 8'h26);
         wr(3'h4, adr);
         check(regs.addr === adr, "address readback");
         wr(3'h0, 8'h29);
         check(regs.addr === msk, "mask slot readback");
         c2 = s ? 8'h80 : 8'($urandom) & 8'h3E;
         wr(3'h0, 8'h26);
         wr(3'h1, c2);
         trial(s[0], adr & 8'hFE, 2);
         trial(s[0], 8'h00, 0);
         for (int i = 0; i < 12; i++) begin
            d = 8'($urandom);
            if (i % 2 == 0) d = adr ^ (d & 8'h3E);
            trial(s[0], d & 8'hFE, i % 3);
         end
         if (s == 0) begin
            wr(3'h0, 8'h27);
            for (int i = 0; i < 6; i++) begin
               hi = 2'($urandom);
               hh = (i < 2) ? ~hi : hi;
               lo = 8'($urandom);
               c2 = (i < 2) ? 8'h3E : 8'($urandom) & 8'h3E;
               b = (i % 2) ? 8'($urandom) : lo ^ (8'($urandom) & 8'h3F);
               wr(3'h1, c2);
               wr(3'h4, {5'h1E, hi, 1'b0});
               begin_frame();
               byte_out({5'h1E, hh, 1'b0}, hh === hi);
               @(negedge clk_i);
               check(regs.stat[1] === (hh === hi), "header flag");
               wr(3'h4, lo);
               byte_out(b, (hh === hi) && hit(b, lo, msk, c2, 1'b0, 1'b1));
               end_frame();
            end
         end else begin
            wr(3'h4, 8'h01);
            wr(3'h0, 8'h28);
            wr(3'h1, 8'h01);
            repeat (20) @(negedge clk_i);
            check(regs.con2[0] === 1'b0 && scl_oe === 1'b1, "master start");
            wr(3'h3, 8'h80 | 8'($urandom));
            repeat (4) @(negedge clk_i);
            check(sda_oe === 1'b0, "first bit");
            repeat (26) @(negedge clk_i);
            check(regs.con2[6] === 1'b0, "bit pace");
            repeat (40) @(negedge clk_i);
            check(regs.con2[6] === 1'b1 && irq === 1'b1, "master byte");
         end
      end
      summarize();
   end
   // a hang is cut short well past the expected run time
   initial begin
      #400_000;
      miscompares++;
      summarize();
   end
endmodule
